/* hcs_pkg.sv */
// shared constants, types and helpers for the hall commutation and speed unit
package hcs_pkg;

	localparam int HALL_W = 3;
	localparam int SEC_W = 3;
	localparam int CNT_W = 16;
	localparam int DUTY_W = 12;
	localparam int VCMD_W = 13;
	localparam int SIN_W = 12;
	localparam int ANG_W = 16;
	localparam int NUM_W = 32;

	// codes that carry no sector meaning, per sensor spacing
	localparam logic [2:0] BAD120_A = 3'h7;
	localparam logic [2:0] BAD120_B = 3'h0;
	localparam logic [2:0] BAD60_A = 3'h2;
	localparam logic [2:0] BAD60_B = 3'h5;

	localparam logic [2:0] SEC_COUNT = 3'h6;
	localparam logic [2:0] SEC_FWD = 3'h1;
	localparam logic [2:0] SEC_REV = 3'h5;
	localparam logic [2:0] LAG_120 = 3'h4;
	localparam logic [2:0] LAG_240 = 3'h2;

	// angle units: a full electrical turn is 2**ANG_W
	localparam logic [ANG_W-1:0] ANG_STEP = 16'h2AAB;
	localparam logic [ANG_W-1:0] ANG_HALF = 16'h1555;
	localparam logic [ANG_W-1:0] ANG_120 = 16'h5555;
	localparam logic [ANG_W-1:0] ANG_240 = 16'hAAAB;

	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [DUTY_W-1:0] DUTY_MID = 12'h800;
	localparam int VCMD_SHIFT = 12;
	localparam logic [SIN_W-1:0] SIN_PEAK = 12'h7FF;

	// first quadrant of the sine, 16 points
	localparam logic [SIN_W-1:0] SIN_QTR [16] = '{
		12'h000, 12'h0C9, 12'h18F, 12'h252, 12'h30F, 12'h3C5, 12'h471, 12'h513,
		12'h5AB, 12'h62E, 12'h6A6, 12'h70D, 12'h763, 12'h7A7, 12'h7D8, 12'h7F5};

	typedef enum logic [1:0] {
		HCS_OFF = 2'b00,
		HCS_POS = 2'b01,
		HCS_NEG = 2'b10
	} hcs_drive_t;

	typedef enum logic {
		HCS_DIV_IDLE = 1'b0,
		HCS_DIV_RUN = 1'b1
	} hcs_div_state_t;

	// one bridge leg: gate enables and the duty for the high side
	typedef struct packed {
		logic hi_on;
		logic lo_on;
		logic [DUTY_W-1:0] duty;
	} hcs_phase_t;

	// sector sum modulo six, both inputs below twelve in total
	function automatic logic [SEC_W-1:0] hcs_mod6(input logic [SEC_W-1:0] a, input logic [SEC_W-1:0] b);
		logic [SEC_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, SEC_COUNT}) begin
			s = s - {1'b0, SEC_COUNT};
		end
		return s[SEC_W-1:0];
	endfunction

	// signed sine of the top six bits of an angle
	function automatic logic signed [SIN_W-1:0] hcs_sine(input logic [ANG_W-1:0] ang);
		logic [1:0] quad;
		logic [4:0] idx;
		logic [SIN_W-1:0] mag;
		quad = ang[ANG_W-1 -: 2];
		idx = quad[0] ? (5'h10 - {1'b0, ang[ANG_W-3 -: 4]}) : {1'b0, ang[ANG_W-3 -: 4]};
		mag = idx[4] ? SIN_PEAK : SIN_QTR[idx[3:0]];
		return quad[1] ? -$signed(mag) : $signed(mag);
	endfunction

endpackage

/* hcs_div.sv */
// sequential restoring divider, one quotient bit per enabled cycle
`timescale 1ns/1ps
`default_nettype none
module hcs_div import hcs_pkg::*; #(
	parameter int N_W = 32,
	parameter int D_W = 16
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic ce_i, // clock enable
	input wire logic start_i, // load operands, restarts any running divide
	input wire logic [N_W-1:0] num_i, // dividend
	input wire logic [D_W-1:0] den_i, // divisor, zero yields zero
	output logic done_o, // one-cycle pulse with a fresh quotient
	output logic [N_W-1:0] quo_o // quotient
);

	localparam int C_W = $clog2(N_W + 1);

	generate
		if (N_W < D_W || D_W < 2) begin : g_bad
			$error("hcs_div: dividend must be at least as wide as divisor");
		end
	endgenerate

	hcs_div_state_t state;
	logic [N_W-1:0] quo;
	logic [D_W-1:0] rem;
	logic [D_W-1:0] den;
	logic [C_W-1:0] cnt;
	logic [D_W:0] shifted;

	assign shifted = {rem, quo[N_W-1]};

	// iterate; a new start always wins over the running divide
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= HCS_DIV_IDLE;
			quo <= '0;
			rem <= '0;
			den <= '0;
			cnt <= '0;
			done_o <= 1'b0;
			quo_o <= '0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i) begin
				quo <= num_i;
				rem <= '0;
				den <= den_i;
				cnt <= C_W'(N_W);
				if (den_i == '0) begin
					// divide by zero is never run: report zero at once
					quo_o <= '0;
					done_o <= 1'b1;
					state <= HCS_DIV_IDLE;
				end else begin
					state <= HCS_DIV_RUN;
				end
			end else begin
				case (state)
					HCS_DIV_IDLE: begin
						state <= HCS_DIV_IDLE;
					end
					HCS_DIV_RUN: begin
						if (shifted >= {1'b0, den}) begin
							rem <= D_W'(shifted - {1'b0, den});
							quo <= {quo[N_W-2:0], 1'b1};
						end else begin
							rem <= shifted[D_W-1:0];
							quo <= {quo[N_W-2:0], 1'b0};
						end
						cnt <= cnt - C_W'(1);
						if (cnt == C_W'(1)) begin
							quo_o <= {quo[N_W-2:0], shifted >= {1'b0, den}};
							done_o <= 1'b1;
							state <= HCS_DIV_IDLE;
						end
					end
					default: begin
						state <= HCS_DIV_IDLE;
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* hcs_top.sv */
// hall decode, interval timing, speed and bridge drive for a brushless motor
//
// What this block does
// - with 120-degree sensors, codes 111 and 000 are invalid and raise a sensor fault.
// - with the 60-degree option, 111 and 000 are valid sectors and 010 and 101 are the invalid codes.
// - each valid code maps to one 60-degree sector whose centre angle is 30 degrees plus 60 per sector.
// - direction comes from the order of code changes, and a reversal marks oscillation and rejects that speed.
// - a 16-bit timer counts cycles between transitions, captured and restarted at each one.
// - speed is a programmable constant divided by the captured interval.
// - every accepted transition not followed by another step or a fault before its divide ends yields a speed update, six per electrical turn.
// - in six-step mode each sector drives one phase high, one low and leaves one undriven.
// - each phase runs positive two sectors, off one, negative two, off one.
// - the six-step pattern changes at the hall transitions.
// - in six-step mode one duty value sets the amplitude of the driven phase.
// - in sinusoidal mode the angle indexes a sine table for three phases 120 degrees apart.
// - in sinusoidal mode each sine value is scaled by the voltage command to form the duty.
`timescale 1ns/1ps
`default_nettype none
module hcs_top import hcs_pkg::*; #(
	parameter int SPD_W = NUM_W
) (
	input wire logic clk_i, // 250 MHz system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic ce_i, // clock enable, low freezes all state
	input wire logic [HALL_W-1:0] hall_i, // hall sensor pins, asynchronous
	input wire logic hall60_i, // high: sensors spaced 60 degrees
	input wire logic sine_mode_i, // high: sinusoidal drive, low: six-step
	input wire logic [SPD_W-1:0] speed_const_i, // dividend for the speed
	input wire logic [DUTY_W-1:0] duty_i, // six-step amplitude
	input wire logic [VCMD_W-1:0] vcmd_i, // voltage command, 0 to 4096
	input wire logic [ANG_W-1:0] angle_i, // high-resolution angle
	output hcs_phase_t [2:0] bridge_o, // legs u, v, w
	output logic [SEC_W-1:0] sector_o, // current sector 0 to 5
	output logic [ANG_W-1:0] sector_angle_o, // centre angle of the sector
	output logic fault_o, // current code is invalid
	output logic dir_rev_o, // last step was reverse
	output logic osc_o, // last step reversed direction
	output logic stall_o, // interval timer saturated
	output logic [CNT_W-1:0] interval_o, // last captured interval
	output logic [SPD_W-1:0] speed_o, // measured speed
	output logic speed_upd_o // one-cycle pulse on a new speed
);

	generate
		if (SPD_W < CNT_W) begin : g_bad
			$error("hcs_top: speed width below interval width");
		end
	endgenerate

	logic [HALL_W-1:0] hall_s1;
	logic [HALL_W-1:0] hall_s2;
	logic [HALL_W-1:0] hall_q;
	logic [1:0] fill;
	logic primed;
	logic code_bad;
	logic [SEC_W-1:0] code_sec;
	logic changed;
	logic [SEC_W-1:0] step;
	logic prev_valid;
	logic [CNT_W-1:0] cnt;
	logic div_start;
	logic [CNT_W-1:0] div_den;
	logic div_done;
	logic [SPD_W-1:0] div_quo;
	logic pending;
	logic [ANG_W-1:0] ang_v;
	logic [ANG_W-1:0] ang_w;

	// two-stage synchroniser; only the second stage feeds logic
	// fill marks when the second stage holds real pin data rather than its cleared 000
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hall_s1 <= '0;
			hall_s2 <= '0;
			fill <= '0;
		end else if (ce_i) begin
			hall_s1 <= hall_i;
			hall_s2 <= hall_s1;
			fill <= {fill[0], 1'b1};
		end
	end

	// validity and sector of the synchronised code
	always_comb begin
		if (hall60_i) begin
			code_bad = (hall_s2 == BAD60_A) || (hall_s2 == BAD60_B);
		end else begin
			code_bad = (hall_s2 == BAD120_A) || (hall_s2 == BAD120_B);
		end
		code_sec = '0;
		if (hall60_i) begin
			case (hall_s2)
				3'h0: code_sec = 3'h0;
				3'h1: code_sec = 3'h1;
				3'h3: code_sec = 3'h2;
				3'h7: code_sec = 3'h3;
				3'h6: code_sec = 3'h4;
				3'h4: code_sec = 3'h5;
				default: code_sec = '0;
			endcase
		end else begin
			case (hall_s2)
				3'h5: code_sec = 3'h0;
				3'h4: code_sec = 3'h1;
				3'h6: code_sec = 3'h2;
				3'h2: code_sec = 3'h3;
				3'h3: code_sec = 3'h4;
				3'h1: code_sec = 3'h5;
				default: code_sec = '0;
			endcase
		end
	end

	// a change is only seen once the previous code has been taken after reset
	assign changed = primed && (hall_s2 != hall_q);
	assign step = hcs_mod6(code_sec, SEC_COUNT - sector_o);

	// sector tracking, fault flag and direction
	// held off until the synchroniser is filled, else the cleared 000 would read as a fault and a step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hall_q <= '0;
			primed <= 1'b0;
			prev_valid <= 1'b0;
			sector_o <= '0;
			sector_angle_o <= ANG_HALF;
			fault_o <= 1'b0;
			dir_rev_o <= 1'b0;
			osc_o <= 1'b0;
		end else if (ce_i && fill[1]) begin
			hall_q <= hall_s2;
			primed <= 1'b1;
			fault_o <= code_bad;
			if (!primed || changed) begin
				prev_valid <= !code_bad;
				if (!code_bad) begin
					sector_o <= code_sec;
					sector_angle_o <= ANG_W'(code_sec * ANG_STEP) + ANG_HALF;
				end
				if (changed && prev_valid && !code_bad && (step == SEC_FWD || step == SEC_REV)) begin
					dir_rev_o <= (step == SEC_REV);
					osc_o <= (step == SEC_REV) != dir_rev_o;
				end
			end
		end
	end

	// interval timer; saturation stops it so an idle motor never wraps to a false speed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= '0;
			interval_o <= CNT_MAX;
			stall_o <= 1'b1;
			div_start <= 1'b0;
			div_den <= '0;
		end else if (ce_i) begin
			div_start <= 1'b0;
			if (changed) begin
				cnt <= '0;
				interval_o <= cnt;
				stall_o <= 1'b0;
				if (prev_valid && !code_bad && (step == SEC_FWD || step == SEC_REV)
					&& ((step == SEC_REV) == dir_rev_o) && cnt != CNT_MAX) begin
					div_start <= 1'b1;
					div_den <= cnt;
				end
			end else if (cnt == CNT_MAX) begin
				stall_o <= 1'b1;
				interval_o <= CNT_MAX;
			end else begin
				cnt <= cnt + CNT_W'(1);
			end
		end
	end

	hcs_div #(
		.N_W(SPD_W),
		.D_W(CNT_W)
	) u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.start_i(div_start),
		.num_i(speed_const_i),
		.den_i(div_den),
		.done_o(div_done),
		.quo_o(div_quo)
	);

	// speed register; stall, fault and oscillation force zero and drop a pending result
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			speed_o <= '0;
			speed_upd_o <= 1'b0;
			pending <= 1'b0;
		end else if (ce_i) begin
			speed_upd_o <= 1'b0;
			if (div_start) begin
				pending <= 1'b1;
			end else if (div_done) begin
				pending <= 1'b0;
			end
			if (cnt == CNT_MAX || code_bad) begin
				speed_o <= '0;
				pending <= 1'b0;
			end else if (changed && prev_valid && !code_bad && (step == SEC_FWD || step == SEC_REV)
				&& ((step == SEC_REV) != dir_rev_o)) begin
				speed_o <= '0;
				pending <= 1'b0;
			end else if (div_done && pending && !div_start) begin
				speed_o <= div_quo;
				speed_upd_o <= 1'b1;
			end
		end
	end

	assign ang_v = angle_i - ANG_120;
	assign ang_w = angle_i - ANG_240;

	// bridge drive per leg; legs v and w lag u by 120 and 240 degrees
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bridge_o <= '0;
		end else if (ce_i) begin
			for (int k = 0; k < 3; k++) begin
				logic [SEC_W-1:0] pos;
				logic [ANG_W-1:0] ang;
				logic signed [SIN_W+VCMD_W:0] prod;
				hcs_drive_t drv;
				pos = hcs_mod6(sector_o, (k == 0) ? 3'h0 : (k == 1) ? LAG_120 : LAG_240);
				ang = (k == 0) ? angle_i : (k == 1) ? ang_v : ang_w;
				// two on, one off, two negative, one off
				drv = (pos < 3'h2) ? HCS_POS : (pos == 3'h2 || pos == 3'h5) ? HCS_OFF : HCS_NEG;
				prod = hcs_sine(ang) * $signed({1'b0, vcmd_i});
				if (sine_mode_i) begin
					bridge_o[k].hi_on <= 1'b1;
					bridge_o[k].lo_on <= 1'b1;
					bridge_o[k].duty <= DUTY_W'(prod >>> VCMD_SHIFT) + DUTY_MID;
				end else if (fault_o) begin
					// an invalid code gives no sector, so the bridge is released
					bridge_o[k] <= '0;
				end else begin
					// one high with duty, one low, one open
					bridge_o[k].hi_on <= (drv == HCS_POS);
					bridge_o[k].lo_on <= (drv == HCS_NEG);
					bridge_o[k].duty <= (drv == HCS_POS) ? duty_i : '0;
				end
			end
		end
	end

endmodule
`default_nettype wire

/* hcs_assertions.sv */
// assertion checker for the hall commutation unit, sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module hcs_assertions import hcs_pkg::*; #(
	parameter int SPD_W = NUM_W
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic ce_i, // enable
	input wire logic [HALL_W-1:0] hall_i, // pins
	input wire logic hall60_i, // spacing
	input wire logic sine_mode_i, // mode
	input wire logic [SPD_W-1:0] speed_const_i, // dividend
	input wire logic [DUTY_W-1:0] duty_i, // duty
	input wire logic [VCMD_W-1:0] vcmd_i, // command
	input wire logic [ANG_W-1:0] angle_i, // angle
	input wire hcs_phase_t [2:0] bridge_o, // legs
	input wire logic [SEC_W-1:0] sector_o, // sector
	input wire logic [ANG_W-1:0] sector_angle_o, // centre
	input wire logic fault_o, // fault
	input wire logic dir_rev_o, // reverse
	input wire logic osc_o, // oscillation
	input wire logic stall_o, // stall
	input wire logic [CNT_W-1:0] interval_o, // interval
	input wire logic [SPD_W-1:0] speed_o, // speed
	input wire logic speed_upd_o // pulse
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// six-step drive settled: mode and fault unchanged over two samples, so the leg register has caught up
	sequence six_prev;
		!sine_mode_i && !fault_o && !$past(sine_mode_i) && !$past(fault_o) && !$past(rst_i) && $past(ce_i);
	endsequence
	// pins held long enough for the two-flop synchroniser to settle
	sequence quiet;
		($stable(hall_i) && $stable(hall60_i) && ce_i && !rst_i) [*5];
	endsequence
	rst_vals_a: assert property ($past(rst_i) |-> stall_o && interval_o == CNT_MAX && speed_o == '0)
		else $error("reset outputs wrong");
	sector_rng_a: assert property (sector_o < SEC_COUNT)
		else $error("sector out of range");
	sector_ang_a: assert property (sector_angle_o == sector_o * ANG_STEP + ANG_HALF)
		else $error("sector angle wrong");
	code_fault_a: assert property (quiet |-> fault_o == (hall60_i ? (hall_i == BAD60_A || hall_i == BAD60_B) :
		(hall_i == BAD120_A || hall_i == BAD120_B))) else $error("fault flag wrong");
	six_legs_a: assert property (six_prev |-> $countones({bridge_o[0].hi_on, bridge_o[1].hi_on, bridge_o[2].hi_on}) == 1
		&& $countones({bridge_o[0].lo_on, bridge_o[1].lo_on, bridge_o[2].lo_on}) == 1) else $error("six-step legs wrong");
	six_duty_a: assert property (six_prev ##0 bridge_o[0].hi_on |-> bridge_o[0].duty == $past(duty_i))
		else $error("six-step duty wrong");
	fault_off_a: assert property (fault_o && $past(fault_o) && !sine_mode_i && !$past(sine_mode_i) |-> bridge_o == '0)
		else $error("legs driven on fault");
	quiet_hold_a: assert property (quiet |-> $stable(sector_o))
		else $error("sector moved without pins");
	stall_zero_a: assert property (stall_o && $past(stall_o) |-> interval_o == CNT_MAX && speed_o == '0)
		else $error("stall outputs wrong");
	osc_zero_a: assert property ($rose(osc_o) |-> ##[0:2] speed_o == '0)
		else $error("speed kept on reversal");
endmodule
`default_nettype wire

/* hcs_hall_model.sv */
// hall sensor model: turns a rotor step position into the three sensor levels
`timescale 1ns/1ps
`default_nettype none
module hcs_hall_model import hcs_pkg::*; (
	input wire logic [2:0] pos_i, // step 0 to 5, 6 and 7 forbidden codes
	input wire logic hall60_i, // sensors spaced 60 degrees
	output logic [HALL_W-1:0] hall_o // sensor levels
);
	localparam logic [2:0] C120 [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	localparam logic [2:0] C60 [6] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4};
	// positions 6 and 7 mimic a broken wire or stuck sensor
	always_comb begin
		if (pos_i > 3'h5) hall_o = hall60_i ? (pos_i[0] ? BAD60_B : BAD60_A) : (pos_i[0] ? BAD120_B : BAD120_A);
		else hall_o = hall60_i ? C60[pos_i] : C120[pos_i];
	end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the hall commutation and speed unit
`timescale 1ns/1ps
`default_nettype none
module testbench import hcs_pkg::*;;
	typedef struct packed {
		logic [2:0] pos;
		logic h60;
		logic [2:0] sec;
		logic flt;
	} hcs_row_t;
	// step position and spacing beside the sector and fault they give
	hcs_row_t rows [14] = '{'{3'h1, 1'b0, 3'h1, 1'b0}, '{3'h2, 1'b0, 3'h2, 1'b0}, '{3'h3, 1'b0, 3'h3, 1'b0},
		'{3'h4, 1'b0, 3'h4, 1'b0}, '{3'h5, 1'b0, 3'h5, 1'b0}, '{3'h0, 1'b0, 3'h0, 1'b0}, '{3'h6, 1'b0, 3'h0, 1'b1},
		'{3'h7, 1'b0, 3'h0, 1'b1}, '{3'h5, 1'b0, 3'h5, 1'b0}, '{3'h0, 1'b1, 3'h0, 1'b0}, '{3'h3, 1'b1, 3'h3, 1'b0},
		'{3'h6, 1'b1, 3'h3, 1'b1}, '{3'h7, 1'b1, 3'h3, 1'b1}, '{3'h1, 1'b1, 3'h1, 1'b0}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic hall60_i = 1'b0;
	logic sine_mode_i = 1'b0;
	logic [2:0] pos = 3'h0;
	logic [HALL_W-1:0] hall_i;
	logic [NUM_W-1:0] speed_const_i = 32'h000F0000;
	logic [DUTY_W-1:0] duty_i = 12'h5A5;
	logic [VCMD_W-1:0] vcmd_i = 13'h0000;
	logic [ANG_W-1:0] angle_i = 16'h0000;
	hcs_phase_t [2:0] bridge_o;
	logic [SEC_W-1:0] sector_o;
	logic [ANG_W-1:0] sector_angle_o;
	logic fault_o, dir_rev_o, osc_o, stall_o, speed_upd_o;
	logic [CNT_W-1:0] interval_o;
	logic [NUM_W-1:0] speed_o;
	logic [11:0] sine_duty [3] = '{12'hBFF, 12'h5C7, 12'h61D};
	int mismatches = 0;
	int tests_run = 0;
	int pulses = 0;
	int n;
	hcs_top u_dut (.*);
	hcs_hall_model u_hall (.pos_i(pos), .hall60_i(hall60_i), .hall_o(hall_i));
	// 4 ns period
	always #2 clk_i = ~clk_i;
	// speed updates counted at the sampling edge
	always @(posedge clk_i) begin
		if (speed_upd_o === 1'b1) pulses <= pulses + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// leg position 0,1 high side, 3,4 low side, 2,5 released; a fault releases all
	task automatic chk_bridge(input logic [2:0] sec, input logic flt);
		int p;
		for (int k = 0; k < 3; k++) begin
			p = (sec + (k == 1 ? 4 : k == 2 ? 2 : 0)) % 6;
			chk({bridge_o[k].hi_on, bridge_o[k].lo_on}, flt ? 0 : p < 2 ? 2 : (p == 3 || p == 4) ? 1 : 0);
			if (!flt && p < 2) chk(bridge_o[k].duty, duty_i);
		end
	endtask
	// pins move at a falling edge, then dwell; transitions d+1 cycles apart capture an interval of d
	task automatic step(input logic [2:0] p, input logic h, input int d);
		@(negedge clk_i);
		pos = p;
		hall60_i = h;
		repeat (d) @(negedge clk_i);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		n = pulses;
		for (int i = 0; i < 14; i++) begin
			step(rows[i].pos, rows[i].h60, 59);
			chk(sector_o, rows[i].sec);
			chk(fault_o, rows[i].flt);
			chk_bridge(rows[i].sec, rows[i].flt);
			if (i < 6) chk(dir_rev_o, 0);
			if (i == 5) chk(pulses - n, 6);
			if (i == 5) chk(interval_o, 59);
			if (i == 5) chk(speed_o, 32'h4115);
		end
		$display("row table done");
		step(3'h0, 1'b0, 59);
		step(3'h1, 1'b0, 59);
		step(3'h2, 1'b0, 59);
		chk({osc_o, dir_rev_o}, 0);
		step(3'h1, 1'b0, 59);
		chk(osc_o, 1);
		chk(speed_o, 0);
		step(3'h0, 1'b0, 59);
		chk({osc_o, dir_rev_o}, 1);
		chk(speed_o, 32'h4115);
		$display("reversal done");
		ce_i = 1'b0;
		step(3'h1, 1'b0, 20);
		chk(sector_o, 3'h0);
		ce_i = 1'b1;
		repeat (10) @(negedge clk_i);
		chk(sector_o, 3'h1);
		$display("enable done");
		step(3'h5, 1'b0, 0);
		n = 0;
		while (stall_o !== 1'b1 && n < 70000) begin
			@(negedge clk_i);
			n++;
		end
		if (n == 70000) begin
			mismatches++;
			test_done();
		end
		chk(interval_o, CNT_MAX);
		chk(speed_o, 0);
		step(3'h4, 1'b0, 9);
		chk(stall_o, 0);
		$display("stall done");
		sine_mode_i = 1'b1;
		angle_i = 16'h4000;
		vcmd_i = 13'h0800;
		repeat (4) @(negedge clk_i);
		for (int k = 0; k < 3; k++) begin
			chk({bridge_o[k].hi_on, bridge_o[k].lo_on}, 3);
			chk(bridge_o[k].duty, sine_duty[k]);
		end
		$display("sine done");
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk(sector_angle_o, 32'h1555);
		chk({stall_o, interval_o}, 32'h1FFFF);
		$display("reset done");
		test_done();
	end
endmodule
bind hcs_top hcs_assertions #(.SPD_W(SPD_W)) u_chk (.*);
`default_nettype wire
